// ### tb/mtp_core_chk.sv
// assertions on the mtp_core ports
`timescale 1ns/1ps
module mtp_core_chk #(
    parameter NOUT = 3
) (
    // clock, reset, bus
    input wire            clk,
    input wire            sys_rst,
    input wire            clk_en,
    input wire            wb_cyc_i,
    input wire            wb_stb_i,
    input wire            wb_we_i,
    input wire            wb_ack_o,
    input wire [31:0]     wb_dat_o,
    // levels and results
    input wire            meas_strobe,
    input wire            pid_active,
    input wire            external_mode,
    input wire [NOUT-1:0] out_terminal,
    input wire            thermal_prealarm_out,
    input wire            prealarm_indication,
    input wire            motor_overload_fault,
    input wire            thermistor_fault,
    input wire            voltage_input_usable,
    input wire            current_input_for_freq,
    input wire            irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
    endsequence
    sequence s_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_answer: assert property (s_req |=> s_pulse)
        else $error("bus request not answered by a one-cycle ack");
    a_ack_single: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_reset_clear: assert property ($fell(sys_rst) |->
        !motor_overload_fault && !thermal_prealarm_out && !irq
        && voltage_input_usable && out_terminal == '0)
        else $error("outputs not cleared by reset");
    a_ind_match: assert property (
        thermal_prealarm_out == prealarm_indication)
        else $error("pre-alarm output and indication differ");
    a_fault_sticky: assert property (motor_overload_fault
        && !(wb_cyc_i && wb_we_i) |=> motor_overload_fault)
        else $error("overload fault dropped without a clear");
    a_therm_strobe: assert property ($rose(thermistor_fault)
        |-> $past(meas_strobe) || $past(meas_strobe, 2))
        else $error("thermistor fault without a measurement");
    a_ext_current: assert property ($past(external_mode)
        && !$past(pid_active) && external_mode && !pid_active
        && $past(clk_en) |-> current_input_for_freq)
        else $error("current input not used in external mode");
endmodule // mtp_core_chk

bind mtp_core mtp_core_chk #(.NOUT(NOUT)) chk_u (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .meas_strobe(meas_strobe), .pid_active(pid_active),
    .external_mode(external_mode), .out_terminal(out_terminal),
    .thermal_prealarm_out(thermal_prealarm_out),
    .prealarm_indication(prealarm_indication),
    .motor_overload_fault(motor_overload_fault),
    .thermistor_fault(thermistor_fault),
    .voltage_input_usable(voltage_input_usable),
    .current_input_for_freq(current_input_for_freq), .irq(irq));

// ### tb/mtp_motor_model.sv
// motor side: current, thermistor and thermal relay
`timescale 1ns/1ps
module mtp_motor_model (
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // settings from the bench
    input  wire [15:0] amps,
    input  wire [15:0] ohms,
    input  wire        hot,
    // toward the block
    output wire [15:0] output_current,
    output wire [15:0] thermistor_res,
    output wire        meas_strobe,
    output wire        relay_trip
);
    reg [1:0]  div_ff;
    reg [15:0] cur_ff;
    reg [15:0] res_ff;
    reg        stb_ff;
    reg        hot_ff;
    // a sample every fourth cycle keeps long integrations short
    always @(posedge clk) begin
        div_ff <= sys_rst ? 2'h0 : div_ff + 2'h1;
        stb_ff <= !sys_rst && div_ff == 2'h3;
        cur_ff <= amps;
        res_ff <= ohms;
        hot_ff <= hot;
    end
    assign output_current = cur_ff;
    assign thermistor_res = res_ff;
    assign meas_strobe    = stb_ff;
    assign relay_trip     = hot_ff;
endmodule // mtp_motor_model

// ### tb/tb_mtp_core.sv
// self-checking bench for mtp_core over wishbone
`timescale 1ns/1ps
`include "mtp_regs.vh"
module tb_mtp_core;
    reg         clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg         clk_en = 1'b1;
    reg         cyc = 1'b0;
    reg         stb = 1'b0;
    reg         we = 1'b0;
    reg  [7:0]  adr = 8'h00;
    reg  [3:0]  sel = 4'hF;
    reg  [31:0] wdat = 32'h0;
    reg         pid_act = 1'b0;
    reg         ext_mode = 1'b0;
    reg         rt_sel = 1'b0;
    reg         ai_sel = 1'b0;
    reg         hot = 1'b0;
    reg  [15:0] amps = 16'h0000;
    reg  [15:0] ohms = 16'h0000;
    reg  [31:0] q;
    reg  [31:0] q2;
    wire [31:0] rdat;
    wire [15:0] cur;
    wire [15:0] res;
    wire [2:0]  oterm;
    wire        ack, strobe, relay, pre, ind, mflt, tflt, eflt, hflt;
    wire        vuse, cuse, irq;
    integer     bad_count = 0;
    integer     check_count = 0;
    integer     cyc_cnt = 0;
    always #4 clk = ~clk;

    mtp_motor_model mdl_u (.clk(clk), .sys_rst(sys_rst), .amps(amps),
        .ohms(ohms), .hot(hot), .output_current(cur),
        .thermistor_res(res), .meas_strobe(strobe), .relay_trip(relay));
    mtp_core dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .output_current(cur), .thermistor_res(res), .meas_strobe(strobe),
        .pid_active(pid_act), .external_mode(ext_mode),
        .in_terminal({2'b00, ai_sel, relay, rt_sel}),
        .out_terminal(oterm), .thermal_prealarm_out(pre),
        .prealarm_indication(ind), .motor_overload_fault(mflt),
        .transistor_overload_fault(tflt), .external_thermal_fault(eflt),
        .thermistor_fault(hflt), .voltage_input_usable(vuse),
        .current_input_for_freq(cuse), .irq(irq));

    task stop_test;
        begin
            if (bad_count == 0 && check_count > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("FAIL %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // request held until the edge that samples ack
    task xfer(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= d;
            @(posedge clk);
            while (ack !== 1'b1) @(posedge clk);
            q = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        begin
            xfer(1'b0, a, 32'h0);
            chk(q, e);
        end
    endtask
    task pulse_rst;
        begin
            sys_rst <= 1'b1;
            tick(2);
            sys_rst <= 1'b0;
            tick(1);
        end
    endtask

    initial begin
        tick(16);
        sys_rst <= 1'b0;
        tick(2);
        clk_en <= 1'b0;
        tick(4);
        clk_en <= 1'b1;
        chk(vuse, 1);
        rdc(`MTP_LVL2_ADDR, 32'h270F);
        rdc(`MTP_THR_LVL_ADDR, 32'h270F);
        rdc(8'h3C, 32'h0);
        xfer(1'b1, `MTP_LVL1_ADDR, 32'h64);
        xfer(1'b1, `MTP_TERM2_ADDR, 32'h006C0800);
        tick(2);
        chk(oterm, 32'h2);
        amps <= 16'h0065;
        while (pre !== 1'b1) @(posedge clk);
        chk(mflt, 0);
        chk(ind, 1);
        chk(oterm, 32'h1);
        while (mflt !== 1'b1) @(posedge clk);
        chk(tflt, 0);
        rdc(`MTP_INTEG2_ADDR, 0);
        xfer(1'b0, `MTP_INTEG1_ADDR, 0);
        chk(|q, 1);
        pulse_rst;
        rdc(`MTP_INTEG1_ADDR, 0);
        chk(mflt, 0);
        // second motor configured, select swaps the pair
        xfer(1'b1, `MTP_LVL1_ADDR, 32'h64);
        xfer(1'b1, `MTP_LVL2_ADDR, 32'h64);
        xfer(1'b1, `MTP_MTYPE2_ADDR, 0);
        xfer(1'b1, `MTP_TERM_ADDR, 32'h00040003);
        amps <= 16'h0096;
        tick(20);
        xfer(1'b0, `MTP_INTEG1_ADDR, 0);
        q2 = q;
        chk(|q2, 1);
        rdc(`MTP_INTEG2_ADDR, 0);
        rt_sel <= 1'b1;
        tick(30);
        xfer(1'b0, `MTP_INTEG1_ADDR, 0);
        chk(q < q2, 1);
        xfer(1'b0, `MTP_INTEG2_ADDR, 0);
        chk(|q, 1);
        xfer(1'b1, `MTP_LVL2_ADDR, 32'h270F);
        xfer(1'b0, `MTP_STAT_ADDR, 0);
        chk(q & 32'hF0, 32'h90);
        rt_sel <= 1'b0;
        tick(4);
        xfer(1'b0, `MTP_STAT_ADDR, 0);
        chk(q & 32'hF0, 32'h60);
        pulse_rst;
        xfer(1'b1, `MTP_LVL1_ADDR, 0);
        tick(40);
        rdc(`MTP_INTEG1_ADDR, 0);
        rdc(`MTP_INTEG2_ADDR, 0);
        // relay on an unassigned terminal, then assigned
        xfer(1'b1, `MTP_TERM_ADDR, 32'h00040003);
        xfer(1'b1, `MTP_IRQ_MASK_ADDR, 32'h08);
        hot <= 1'b1;
        tick(8);
        chk(eflt, 0);
        xfer(1'b1, `MTP_TERM_ADDR, 32'h00040703);
        tick(8);
        chk(eflt, 1);
        chk(irq, 1);
        xfer(1'b0, `MTP_IRQ_STAT_ADDR, 0);
        chk(q & 32'h08, 32'h08);
        xfer(1'b1, `MTP_IRQ_MASK_ADDR, 0);
        tick(2);
        chk(irq, 0);
        hot <= 1'b0;
        tick(4);
        xfer(1'b1, `MTP_IRQ_STAT_ADDR, 32'h08);
        xfer(1'b1, `MTP_IRQ_MASK_ADDR, 32'h08);
        tick(2);
        chk(irq, 0);
        // thermistor enabled, bad level refused, trip at equality
        ohms <= 16'h0320;
        xfer(1'b1, `MTP_THR_LVL_ADDR, 32'h3E8);
        tick(12);
        chk(vuse, 0);
        rdc(`MTP_THR_RES_ADDR, 32'h320);
        xfer(1'b1, `MTP_THR_LVL_ADDR, 32'h64);
        rdc(`MTP_THR_LVL_ADDR, 32'h3E8);
        chk(hflt, 0);
        ohms <= 16'h03E8;
        tick(12);
        chk(hflt, 1);
        ext_mode <= 1'b1;
        tick(3);
        chk(cuse, 1);
        ext_mode <= 1'b0;
        xfer(1'b1, `MTP_MODE_ADDR, 32'h04);
        tick(6);
        chk(cuse, 1);
        xfer(1'b1, `MTP_MODE_ADDR, 32'h03);
        tick(6);
        chk(cuse, 0);
        ai_sel <= 1'b1;
        tick(6);
        chk(cuse, 1);
        stop_test;
    end

    // longest wait is the slow climb to trip, well under this
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 60000) begin
            bad_count = bad_count + 1;
            stop_test;
        end
    end
endmodule // tb_mtp_core

// ### verilog/mtp_core.v
// motor thermal protection: integrals, faults, terminals, wishbone regs
//
// Overview of operation
// - active motor integrates measured output current
// - cooling motor integrates with zero current
// - first level zero never integrates motor one
// - valid second level: select picks motor two
// - no valid second level and no second type: only motor one integrates
// - second type set, second level not zero: select swaps motors
// - pre-alarm at 85 percent of level
// - trip at 100 percent of level
// - pre-alarm alone never trips
// - pre-alarm on terminals coded 8 or 108
// - external relay input trips with fault
// - external relay only on terminal code 7
// - thermistor active unless level is 9999
// - active thermistor blocks voltage analog use
// - mode 4/external: current input used unless pid_active
// - mode 3: current input only with select
// - reset clears thermal integrals
// - thermistor level 0.5 to 30k, 9999 off
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "mtp_regs.vh"

module mtp_core #(
    parameter IW    = 32,
    parameter NIN   = 5,
    parameter NOUT  = 3
) (
    // clock and reset
    input  wire            clk,
    input  wire            sys_rst,
    input  wire            clk_en,
    // wishbone slave
    input  wire            wb_cyc_i,
    input  wire            wb_stb_i,
    input  wire            wb_we_i,
    input  wire [7:0]      wb_adr_i,
    input  wire [3:0]      wb_sel_i,
    input  wire [31:0]     wb_dat_i,
    output reg  [31:0]     wb_dat_o,
    output reg             wb_ack_o,
    // measurements, same clock
    input  wire [15:0]     output_current,
    input  wire [15:0]     thermistor_res,
    input  wire            meas_strobe,
    input  wire            pid_active,
    input  wire            external_mode,
    // terminals from pins
    input  wire [NIN-1:0]  in_terminal,
    // results
    output reg  [NOUT-1:0] out_terminal,
    output reg             thermal_prealarm_out,
    output reg             prealarm_indication,
    output reg             motor_overload_fault,
    output reg             transistor_overload_fault,
    output reg             external_thermal_fault,
    output reg             thermistor_fault,
    output reg             voltage_input_usable,
    output reg             current_input_for_freq,
    output reg             irq
);
    // settings
    reg  [15:0]         lvl1_ff, lvl2_ff, mtype2_ff, thr_lvl_ff;
    reg  [8*NIN-1:0]    in_fn_ff;
    reg  [8*NOUT-1:0]   out_fn_ff;
    reg  [7:0]          opmode_ff;
    reg  [`MTP_EV_W-1:0] ist_ff, imask_ff;
    reg  [IW-1:0]       integ1_ff, integ2_ff;
    reg  [15:0]         thr_disp_ff;
    reg  [NIN-1:0]      in_s1_ff, in_s2_ff;
    integer             i;

    // second-function select (code 3) and current-input select (code 4)
    function has_fn;
        input [8*NIN-1:0] fn;
        input [NIN-1:0]   lv;
        input [7:0]       code;
        integer k;
        begin
            has_fn = 1'b0;
            for (k = 0; k < NIN; k = k + 1)
                if (fn[8*k +: 8] == code && lv[k])
                    has_fn = 1'b1;
        end
    endfunction

    // integral += i^2 - level^2 ; saturate at zero
    function [IW-1:0] integ_step;
        input [IW-1:0] acc;
        input [15:0]   cur;
        input [15:0]   lvl;
        reg   [IW:0]   up;
        reg   [31:0]   heat, cool;
        begin
            heat = cur * cur;
            cool = lvl * lvl;
            up   = {1'b0, acc} + {1'b0, heat};
            if (up[IW])
                up = {1'b0, {IW{1'b1}}};
            if (up[IW-1:0] > cool[IW-1:0])
                integ_step = up[IW-1:0] - cool[IW-1:0];
            else
                integ_step = {IW{1'b0}};
        end
    endfunction

    // limit = pct/100 * level^2 * 100, compared as acc*100 >= pct*lim
    function reached;
        input [IW-1:0] acc;
        input [15:0]   lvl;
        input [6:0]    pct;
        reg   [63:0]   lhs, rhs;
        reg   [31:0]   sq;
        begin
            sq  = lvl * lvl;
            lhs = {32'h0, acc} * 64'd100;
            rhs = {32'h0, sq} * {57'h0, pct} * 64'd100;
            reached = (lvl != `MTP_LVL_ZERO) && (lhs >= rhs);
        end
    endfunction

    wire sel_second   = has_fn(in_fn_ff, in_s2_ff, 8'h03);
    wire au_on        = has_fn(in_fn_ff, in_s2_ff, 8'h04);
    wire oh_on        = has_fn(in_fn_ff, in_s2_ff, `MTP_IN_FN_OH);
    wire l1_zero      = (lvl1_ff == `MTP_LVL_ZERO);
    wire l2_unused    = (lvl2_ff == `MTP_UNUSED);
    wire l2_zero      = (lvl2_ff == `MTP_LVL_ZERO);
    wire t2_unused    = (mtype2_ff == `MTP_UNUSED);
    wire thr_on       = (thr_lvl_ff != `MTP_UNUSED);

    // per-motor mode: 2'b10 integrate, 2'b01 cool, 2'b00 off
    reg [1:0] m1_mode, m2_mode;
    always @* begin
        m1_mode = 2'b00;
        m2_mode = 2'b00;
        if (!l2_unused && !l2_zero) begin
            m1_mode = sel_second ? 2'b01 : 2'b10;
            m2_mode = sel_second ? 2'b10 : 2'b01;
        end else if (l2_unused && !t2_unused) begin
            m1_mode = sel_second ? 2'b01 : 2'b10;
            m2_mode = sel_second ? 2'b10 : 2'b01;
        end else if (l2_zero) begin
            m1_mode = sel_second ? 2'b01 : 2'b10;
        end else begin
            m1_mode = 2'b10;
        end
        if (l1_zero) begin
            m1_mode = 2'b00;
            if (l2_unused)
                m2_mode = 2'b00;
        end
    end

    wire [15:0] lvl2_eff  = l2_unused ? lvl1_ff : lvl2_ff;
    wire        act2      = (m2_mode == 2'b10);
    wire [IW-1:0] act_int = act2 ? integ2_ff : integ1_ff;
    wire [15:0]   act_lvl = act2 ? lvl2_eff : lvl1_ff;
    wire pre_hit  = (m1_mode[1] || act2) &&
                    reached(act_int, act_lvl, `MTP_PRE_PCT);
    wire trip_hit = (m1_mode[1] || act2) &&
                    reached(act_int, act_lvl, `MTP_TRIP_PCT);
    wire thr_hit  = thr_on && meas_strobe &&
                    (thermistor_res >= thr_lvl_ff);

    wire [`MTP_EV_W-1:0] ev;
    assign ev[`MTP_EV_PRE]   = pre_hit && !thermal_prealarm_out;
    assign ev[`MTP_EV_MOTOR] = trip_hit && !l1_zero && !motor_overload_fault;
    assign ev[`MTP_EV_TRANS] = trip_hit && l1_zero &&
                               !transistor_overload_fault;
    assign ev[`MTP_EV_EXT]   = oh_on && !external_thermal_fault;
    assign ev[`MTP_EV_THERM] = thr_hit && !thermistor_fault;

    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // write lands on the edge where the master sees ack
    wire wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

    // byte-lane merge of a write into a 32-bit value
    function [31:0] merge;
        input [31:0] old;
        input [31:0] dat;
        input [3:0]  sel;
        integer b;
        begin
            for (b = 0; b < 4; b = b + 1)
                merge[8*b +: 8] = sel[b] ? dat[8*b +: 8] : old[8*b +: 8];
        end
    endfunction

    // terminal codes span two words: input codes from bit 0, output codes above them
    reg [63:0] term_all;
    always @* begin
        term_all = 64'h0;
        term_all[8*NIN+8*NOUT-1:0] = {out_fn_ff, in_fn_ff};
    end
    wire [63:0] term_lo_wr = {term_all[63:32],
                              merge(term_all[31:0], wb_dat_i, wb_sel_i)};
    wire [63:0] term_hi_wr = {merge(term_all[63:32], wb_dat_i, wb_sel_i),
                              term_all[31:0]};
    wire [31:0] l1_wr = merge({16'h0000, lvl1_ff}, wb_dat_i, wb_sel_i);
    wire [31:0] l2_wr = merge({16'h0000, lvl2_ff}, wb_dat_i, wb_sel_i);
    wire [31:0] t2_wr = merge({16'h0000, mtype2_ff}, wb_dat_i, wb_sel_i);

    wire ctl_clr  = wb_wr && wb_adr_i == `MTP_CTRL_ADDR && wb_sel_i[0] &&
                    wb_dat_i[`MTP_CTRL_CLR];
    wire flt_clr  = wb_wr && wb_adr_i == `MTP_CTRL_ADDR && wb_sel_i[0] &&
                    wb_dat_i[`MTP_CTRL_FLT_CLR];
    wire any_flt  = motor_overload_fault || transistor_overload_fault ||
                    external_thermal_fault || thermistor_fault;

    reg [31:0] rd;
    always @* begin
        rd = 32'h0000_0000;
        if (wb_adr_i == `MTP_LVL1_ADDR)
            rd = {16'h0000, lvl1_ff};
        else if (wb_adr_i == `MTP_LVL2_ADDR)
            rd = {16'h0000, lvl2_ff};
        else if (wb_adr_i == `MTP_MTYPE2_ADDR)
            rd = {16'h0000, mtype2_ff};
        else if (wb_adr_i == `MTP_THR_LVL_ADDR)
            rd = {16'h0000, thr_lvl_ff};
        else if (wb_adr_i == `MTP_TERM_ADDR)
            rd = term_all[31:0];
        else if (wb_adr_i == `MTP_TERM2_ADDR)
            rd = term_all[63:32];
        else if (wb_adr_i == `MTP_MODE_ADDR)
            rd = {24'h000000, opmode_ff};
        else if (wb_adr_i == `MTP_STAT_ADDR)
            rd = {24'h000000, m2_mode, m1_mode, any_flt, thr_on,
                  sel_second, thermal_prealarm_out};
        else if (wb_adr_i == `MTP_IRQ_STAT_ADDR)
            rd = {{(32-`MTP_EV_W){1'b0}}, ist_ff};
        else if (wb_adr_i == `MTP_IRQ_MASK_ADDR)
            rd = {{(32-`MTP_EV_W){1'b0}}, imask_ff};
        else if (wb_adr_i == `MTP_INTEG1_ADDR)
            rd = integ1_ff;
        else if (wb_adr_i == `MTP_INTEG2_ADDR)
            rd = integ2_ff;
        else if (wb_adr_i == `MTP_THR_RES_ADDR)
            rd = {16'h0000, thr_disp_ff};
    end

    // pin terminals: pre-alarm with polarity per function code
    reg [NOUT-1:0] nxt_out;
    always @* begin
        for (i = 0; i < NOUT; i = i + 1) begin
            if (out_fn_ff[8*i +: 8] == `MTP_OUT_FN_HI)
                nxt_out[i] = pre_hit;
            else if (out_fn_ff[8*i +: 8] == `MTP_OUT_FN_LO)
                nxt_out[i] = !pre_hit;
            else
                nxt_out[i] = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            lvl1_ff <= `MTP_LVL1_RST;
            lvl2_ff <= `MTP_LVL2_RST;
            mtype2_ff <= `MTP_MTYPE2_RST;
            thr_lvl_ff <= `MTP_THR_LVL_RST;
            in_fn_ff <= {(8*NIN){1'b0}};
            out_fn_ff <= {(8*NOUT){1'b0}};
            opmode_ff <= 8'h00;
            ist_ff <= {`MTP_EV_W{1'b0}};
            imask_ff <= {`MTP_EV_W{1'b0}};
            integ1_ff <= {IW{1'b0}};
            integ2_ff <= {IW{1'b0}};
            thr_disp_ff <= 16'h0000;
            in_s1_ff <= {NIN{1'b0}};
            in_s2_ff <= {NIN{1'b0}};
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            out_terminal <= {NOUT{1'b0}};
            thermal_prealarm_out <= 1'b0;
            prealarm_indication <= 1'b0;
            motor_overload_fault <= 1'b0;
            transistor_overload_fault <= 1'b0;
            external_thermal_fault <= 1'b0;
            thermistor_fault <= 1'b0;
            voltage_input_usable <= 1'b1;
            current_input_for_freq <= 1'b0;
            irq <= 1'b0;
        end else if (clk_en) begin
            // all pin inputs pass two flops; one bank feeds every use
            in_s1_ff <= in_terminal;
            in_s2_ff <= in_s1_ff;
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd : 32'h0000_0000;
            if (wb_wr) begin
                if (wb_adr_i == `MTP_LVL1_ADDR)
                    lvl1_ff <= (l1_wr > {16'h0000, `MTP_LVL_MAX}) ?
                               `MTP_LVL_MAX : l1_wr[15:0];
                else if (wb_adr_i == `MTP_LVL2_ADDR)
                    lvl2_ff <= l2_wr[15:0];
                else if (wb_adr_i == `MTP_MTYPE2_ADDR)
                    mtype2_ff <= t2_wr[15:0];
                else if (wb_adr_i == `MTP_THR_LVL_ADDR) begin
                    // out-of-range values other than 9999 are ignored
                    if (wb_dat_i[15:0] == `MTP_UNUSED ||
                        (wb_dat_i[15:0] >= `MTP_THR_MIN &&
                         wb_dat_i[15:0] <= `MTP_THR_MAX))
                        thr_lvl_ff <= wb_dat_i[15:0];
                end else if (wb_adr_i == `MTP_TERM_ADDR)
                    {out_fn_ff, in_fn_ff} <= term_lo_wr[8*NIN+8*NOUT-1:0];
                else if (wb_adr_i == `MTP_TERM2_ADDR)
                    {out_fn_ff, in_fn_ff} <= term_hi_wr[8*NIN+8*NOUT-1:0];
                else if (wb_adr_i == `MTP_MODE_ADDR && wb_sel_i[0])
                    opmode_ff <= wb_dat_i[7:0];
                else if (wb_adr_i == `MTP_IRQ_MASK_ADDR && wb_sel_i[0])
                    imask_ff <= wb_dat_i[`MTP_EV_W-1:0];
            end
            // set wins over write-one-to-clear
            if (wb_wr && wb_adr_i == `MTP_IRQ_STAT_ADDR && wb_sel_i[0])
                ist_ff <= (ist_ff & ~wb_dat_i[`MTP_EV_W-1:0]) | ev;
            else
                ist_ff <= ist_ff | ev;
            irq <= |((ist_ff | ev) & imask_ff);
            // integrate once per measurement
            if (ctl_clr) begin
                integ1_ff <= {IW{1'b0}};
                integ2_ff <= {IW{1'b0}};
            end else if (meas_strobe) begin
                if (m1_mode == 2'b10)
                    integ1_ff <= integ_step(integ1_ff, output_current,
                                            lvl1_ff);
                else if (m1_mode == 2'b01)
                    integ1_ff <= integ_step(integ1_ff, 16'h0000,
                                            lvl1_ff);
                if (m2_mode == 2'b10)
                    integ2_ff <= integ_step(integ2_ff, output_current,
                                            lvl2_eff);
                else if (m2_mode == 2'b01)
                    integ2_ff <= integ_step(integ2_ff, 16'h0000,
                                            lvl2_eff);
            end
            thr_disp_ff <= thr_on ? thermistor_res : 16'h0000;
            // pre-alarm is indication only, faults stay separate
            thermal_prealarm_out <= pre_hit;
            prealarm_indication <= pre_hit;
            out_terminal <= nxt_out;
            // faults latch until software clears them, the external one only while its relay input is off; new event wins
            if (ev[`MTP_EV_MOTOR])
                motor_overload_fault <= 1'b1;
            else if (flt_clr)
                motor_overload_fault <= 1'b0;
            if (ev[`MTP_EV_TRANS])
                transistor_overload_fault <= 1'b1;
            else if (flt_clr)
                transistor_overload_fault <= 1'b0;
            if (ev[`MTP_EV_EXT])
                external_thermal_fault <= 1'b1;
            else if (flt_clr && !oh_on)
                external_thermal_fault <= 1'b0;
            if (ev[`MTP_EV_THERM])
                thermistor_fault <= 1'b1;
            else if (flt_clr)
                thermistor_fault <= 1'b0;
            voltage_input_usable <= !thr_on;
            if (pid_active)
                current_input_for_freq <= 1'b0;
            else if (opmode_ff == `MTP_OPMODE_EXT4 || external_mode)
                current_input_for_freq <= 1'b1;
            else if (opmode_ff == `MTP_OPMODE_AU3)
                current_input_for_freq <= au_on;
            else
                current_input_for_freq <= 1'b0;
        end
    end
endmodule // mtp_core

// ### verilog/mtp_regs.vh
// register offsets, field positions, reset values and constants of mtp
`ifndef MTP_REGS_VH
`define MTP_REGS_VH
// register byte offsets
`define MTP_CTRL_ADDR      8'h00
`define MTP_LVL1_ADDR      8'h04
`define MTP_LVL2_ADDR      8'h08
`define MTP_MTYPE2_ADDR    8'h0C
`define MTP_THR_LVL_ADDR   8'h10
`define MTP_TERM_ADDR      8'h14
`define MTP_MODE_ADDR      8'h18
`define MTP_STAT_ADDR      8'h1C
`define MTP_IRQ_STAT_ADDR  8'h20
`define MTP_IRQ_MASK_ADDR  8'h24
`define MTP_INTEG1_ADDR    8'h28
`define MTP_INTEG2_ADDR    8'h2C
`define MTP_THR_RES_ADDR   8'h30
`define MTP_TERM2_ADDR     8'h34
// special setting values
`define MTP_UNUSED         16'h270F
`define MTP_LVL_ZERO       16'h0000
`define MTP_LVL_MAX        16'hC350
`define MTP_THR_MIN        16'h01F4
`define MTP_THR_MAX        16'h7530
`define MTP_OUT_FN_HI      8'h08
`define MTP_OUT_FN_LO      8'h6C
`define MTP_IN_FN_OH       8'h07
`define MTP_OPMODE_EXT4    8'h04
`define MTP_OPMODE_AU3     8'h03
// reset values
`define MTP_LVL1_RST       16'h2710
`define MTP_LVL2_RST       16'h270F
`define MTP_MTYPE2_RST     16'h270F
`define MTP_THR_LVL_RST    16'h270F
// percentages
`define MTP_PRE_PCT        7'd85
`define MTP_TRIP_PCT       7'd100
// status / irq bits
`define MTP_EV_PRE         0
`define MTP_EV_MOTOR       1
`define MTP_EV_TRANS       2
`define MTP_EV_EXT         3
`define MTP_EV_THERM       4
`define MTP_EV_W           5
// ctrl bits
`define MTP_CTRL_CLR       0
`define MTP_CTRL_FLT_CLR   1
`endif
